// [src/dsmul_consts.svh]
`ifndef DSMUL_CONSTS_SVH
`define DSMUL_CONSTS_SVH
// Accumulator width and derived cell geometry
`define DSMUL_W        32
`define DSMUL_MSB      31
// Instruction size of the no-operation, in bytes
`define DSMUL_NOP_BYTES 1
// Default depth of the RAM-address stack
`define DSMUL_STK_DEPTH 8
// Largest stack depth the pointer logic is sized for
`define DSMUL_STK_MAX  64
// Width of the RAM address pointer
`define DSMUL_RAD_W    7
// Reset values
`define DSMUL_ACC_RST  32'h0000_0000
`define DSMUL_RAD_RST  7'h00
`endif

// [src/dsmul_pkg.sv]
package dsmul_pkg;
  // Operation selected for one execution slot
  typedef enum logic [4:0] {
    DSMUL_OP_IDLE = 5'h01,
    DSMUL_OP_MUL  = 5'h02,
    DSMUL_OP_NOP  = 5'h04,
    DSMUL_OP_PUSH = 5'h08,
    DSMUL_OP_POP  = 5'h10
  } dsmul_op_e;

  // Three accumulators seen by the multiply step
  typedef struct packed {
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] mcand;
  } dsmul_acc_s;

  // One issued instruction slot
  typedef struct packed {
    logic        valid;
    dsmul_op_e   op;
    logic        load;
    dsmul_acc_s  load_val;
    logic [6:0]  rad_new;
  } dsmul_cmd_s;
endpackage : dsmul_pkg

// [src/dsmul_step.sv]
`timescale 1ns/1ps
`include "dsmul_consts.svh"
module dsmul_step #(
  parameter int STK_DEPTH = `DSMUL_STK_DEPTH
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire dsmul_pkg::dsmul_cmd_s cmd,
  output logic                     done_q,
  output dsmul_pkg::dsmul_acc_s    acc_q,
  output logic [`DSMUL_RAD_W-1:0]  rad_q,
  output logic                     stk_empty_q
);

  // Elaboration check: an empty stack or one wider than the pointer range cannot be served
  if (STK_DEPTH < 1 || STK_DEPTH > `DSMUL_STK_MAX) begin : g_bad_depth
    $error("STK_DEPTH out of range");
  end

  localparam int SPW = $clog2(STK_DEPTH + 1);

  typedef struct packed {
    logic                               done;
    dsmul_pkg::dsmul_acc_s              acc;
    logic [`DSMUL_RAD_W-1:0]            rad;
    logic [SPW-1:0]                     sp;
    logic [STK_DEPTH-1:0][`DSMUL_RAD_W-1:0] stk;
  } dsmul_state_s;

  dsmul_state_s st_q;
  dsmul_state_s st_d;

  // One partial-product iteration over the 64-bit pair
  function automatic dsmul_pkg::dsmul_acc_s mul_step(input dsmul_pkg::dsmul_acc_s a);
    logic [`DSMUL_W:0] sum;
    dsmul_pkg::dsmul_acc_s r;
    sum = {1'b0, a.hi} + ({1'b0, a.mcand} & {(`DSMUL_W+1){a.lo[0]}});
    r = a;
    r.hi = {1'b0, sum[`DSMUL_MSB:1]};
    // Low cell takes sum bit 0
    r.lo = {sum[0], a.lo[`DSMUL_MSB:1]};
    r.mcand = a.mcand;
    return r;
  endfunction : mul_step

  // Next-state: one operation per slot, applied after any load of the cells in the same slot
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (cmd.valid) begin
      st_d.done = 1'b1;
      if (cmd.load) begin
        st_d.acc = cmd.load_val; // Program loads / clears cells
      end
      case (cmd.op)
        dsmul_pkg::DSMUL_OP_MUL: begin
          // Truncated runs leave the product shifted left by 32 minus the step count
          // Works on the loaded cells when a load shares the slot
          st_d.acc = mul_step(st_d.acc);
        end
        dsmul_pkg::DSMUL_OP_NOP: begin
          // Only done is raised
          // A load in the same slot still applies; the op itself touches nothing
          st_d.done = 1'b1;
        end
        dsmul_pkg::DSMUL_OP_PUSH: begin
          // Save current pointer; a full stack drops the oldest entry
          if (st_q.sp == SPW'(STK_DEPTH)) begin
            st_d.stk = st_q.stk >> `DSMUL_RAD_W;
            st_d.stk[STK_DEPTH-1] = st_q.rad;
          end else begin
            st_d.stk[st_q.sp] = st_q.rad;
            st_d.sp = st_q.sp + SPW'(1);
          end
          st_d.rad = cmd.rad_new;
        end
        dsmul_pkg::DSMUL_OP_POP: begin
          if (st_q.sp != '0) begin
            st_d.rad = st_q.stk[st_q.sp - SPW'(1)];
            st_d.sp  = st_q.sp - SPW'(1);
          end
        end
        default: begin
          st_d.done = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Registered outputs, loaded from next state on the same edge as the state register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_q      <= 1'b0;
      acc_q       <= '0;
      rad_q       <= `DSMUL_RAD_RST;
      stk_empty_q <= 1'b1;
    end else begin
      done_q      <= st_d.done;
      acc_q       <= st_d.acc;
      rad_q       <= st_d.rad;
      stk_empty_q <= (st_d.sp == '0);
    end
  end

endmodule : dsmul_step

// [test/dsmul_step_assertions.sv]
`timescale 1ns/1ps
module dsmul_step_chk (
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire dsmul_pkg::dsmul_cmd_s cmd,
  input wire logic                  done_q,
  input wire dsmul_pkg::dsmul_acc_s acc_q,
  input wire logic [6:0]            rad_q,
  input wire logic                  stk_empty_q
);
  logic [31:0] s;
  logic        g, m, u;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Sum cut to 32 bits, since bit 31 of the new high cell is zero
  assign s = acc_q.hi + (acc_q.lo[0] ? acc_q.mcand : 32'h0);
  assign g = cmd.valid && !cmd.load;
  assign m = g && cmd.op == 5'h02;
  assign u = g && cmd.op == 5'h08;
  property p_hi; m |=> acc_q.hi == {1'b0, $past(s[31:1])}; endproperty
  a_hi: assert property (p_hi) else $error("hi step");
  property p_lo; m |=> acc_q.lo == {$past(s[0]), $past(acc_q.lo[31:1])}; endproperty
  a_lo: assert property (p_lo) else $error("lo step");
  property p_mc; g |=> $stable(acc_q.mcand); endproperty
  a_mc: assert property (p_mc) else $error("mcand");
  property p_dn; cmd.valid && cmd.op != 5'h01 |=> done_q; endproperty
  a_dn: assert property (p_dn) else $error("done");
  property p_nop; g && cmd.op == 5'h04 |=> $stable(acc_q) && $stable(rad_q); endproperty
  a_nop: assert property (p_nop) else $error("nop");
  property p_pop; u ##1 (g && cmd.op == 5'h10) |=> rad_q == $past(rad_q, 2); endproperty
  a_pop: assert property (p_pop) else $error("pop");
  c_mul: cover property (m ##1 m);
  c_pop: cover property (u ##1 cmd.op == 5'h10);
  c_emp: cover property (cmd.op == 5'h10 && stk_empty_q);
endmodule : dsmul_step_chk
bind dsmul_step dsmul_step_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .cmd(cmd), .done_q(done_q),
  .acc_q(acc_q), .rad_q(rad_q), .stk_empty_q(stk_empty_q));

// [test/dsmul_step_bench.sv]
`timescale 1ns/1ps
module dsmul_step_bench;
  logic clk_sys, rstn, done_q, stk_empty_q;
  dsmul_pkg::dsmul_cmd_s cmd;
  dsmul_pkg::dsmul_acc_s acc_q;
  logic [6:0] rad_q, r;
  logic [31:0] a, b;
  int fail_count, compares, n;
  dsmul_step u_dut (.clk_sys(clk_sys), .rstn(rstn), .cmd(cmd), .done_q(done_q), .acc_q(acc_q),
    .rad_q(rad_q), .stk_empty_q(stk_empty_q));
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  task end_sim;
    $display("compares %0d fails %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task chk(input string w, input logic [63:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s exp %h seen %h", w, e, s);
    end
  endtask : chk
  // One slot, taken at the next edge
  task sl(input logic [4:0] o, input logic l, input logic [95:0] v, input logic [6:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, dsmul_pkg::dsmul_op_e'(o), l, v, d};
  endtask : sl
  task id;
    @(posedge clk_sys);
    cmd.valid <= 1'b0;
    #1;
  endtask : id
  initial begin
    #200000 fail_count++;
    end_sim();
  end
  initial begin
    rstn = 0;
    cmd = '0;
    void'($urandom(41225));
    repeat (20) @(posedge clk_sys);
    rstn <= 1;
    // Load clears hi; 32 and 1 steps are the corner counts
    for (int i = 0; i < 6; i++) begin
      n = i == 0 ? 32 : i == 1 ? 1 : $urandom_range(31, 2);
      a = $urandom() >> (32 - n);
      b = $urandom() >> 1;
      sl(5'h02, 1, {32'h0, a, b}, 0);
      repeat (n - 1) sl(5'h02, 0, 0, 0);
      id();
      chk("prod", {acc_q.hi, acc_q.lo}, ({32'h0, a} * b) << (32 - n));
      chk("mcand", acc_q.mcand, b);
      chk("done", done_q, 1);
    end
    $display("mul end");
    sl(5'h04, 1, {a, b, a}, 0);
    sl(5'h04, 0, 0, 0);
    id();
    chk("nop", {acc_q.hi, acc_q.lo}, {a, b});
    r = $urandom_range(127, 1);
    sl(5'h08, 0, 0, r);
    sl(5'h08, 0, 0, ~r);
    sl(5'h10, 0, 0, 0);
    id();
    chk("pop", rad_q, r);
    sl(5'h10, 0, 0, 0);
    sl(5'h10, 0, 0, 0);
    id();
    chk("empty", {rad_q, stk_empty_q}, 1);
    // Overfill by one: the oldest saved pointer is dropped
    for (int i = 1; i <= 9; i++) sl(5'h08, 0, 0, i);
    repeat (9) sl(5'h10, 0, 0, 0);
    id();
    chk("full", {rad_q, stk_empty_q}, 3);
    $display("misc end");
    end_sim();
  end
endmodule : dsmul_step_bench
